/* tb/cspcg_osc_model.sv */
`timescale 1ns/1ns
// Crystal or external clock source seen at the first oscillator pin
module cspcg_osc_model #(
    parameter int HALF_NS  = 100,
    parameter int START_NS = 13
) (
    firstOscPin
);
    output logic firstOscPin;

    // Free-running source, phase offset keeps edges away from core edges
    initial
    begin
        firstOscPin = 1'b0;
        #(START_NS);
        forever
        begin
            #(HALF_NS) firstOscPin = ~firstOscPin;
        end
    end
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ns
module testbench;
    logic       core_clk = 1'b0;
    logic       srst     = 1'b1;
    logic [7:0] optionWord = 8'h00;
    logic       firstOscPin;
    logic       haltReq  = 1'b0;
    logic       stopReq  = 1'b0;
    logic       wakeIrq  = 1'b0;
    logic [2:0] regAddr  = 3'h0;
    logic [7:0] regWdata = 8'h00;
    logic       regWr    = 1'b0;
    logic       regRd    = 1'b0;
    logic [7:0] regRdata;
    logic       cpuClkEn, periphClkEn, sysClkEn, slowClkEn, wdtClkEn, auxTimerClkEn;
    logic       secondPinFree;
    logic       cpuRun;
    logic [5:0] enVec;
    int         miscompares = 0;
    int         comparisons = 0;
    int         tr, te, tc, n;
    logic [7:0] rv;

    assign enVec = {cpuClkEn, periphClkEn, sysClkEn, slowClkEn, wdtClkEn, auxTimerClkEn};

    // Clock generation
    always #20 core_clk = ~core_clk;

    cspcg_core #(.SETTLE_EXP0(2), .SETTLE_EXP1(3), .SETTLE_EXP2(4), .SETTLE_EXP3(5)) u_cspcg_core (
        .core_clk(core_clk), .srst(srst), .optionWord(optionWord),
        .firstOscPin(firstOscPin), .haltReq(haltReq), .stopReq(stopReq),
        .wakeIrq(wakeIrq), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .cpuClkEn(cpuClkEn),
        .periphClkEn(periphClkEn), .sysClkEn(sysClkEn), .slowClkEn(slowClkEn),
        .wdtClkEn(wdtClkEn), .auxTimerClkEn(auxTimerClkEn),
        .secondPinFree(secondPinFree), .cpuRun(cpuRun)
    );

    cspcg_osc_model u_cspcg_osc_model (
        .firstOscPin(firstOscPin)
    );

    // Comparison and verdict
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic results();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Register port accesses
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regWr <= 1'b1; regAddr <= a; regWdata <= d;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge core_clk);
        regRd <= 1'b1; regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'b0;
        @(negedge core_clk);
        d = regRdata;
    endtask

    // One-cycle pulse on a request input
    task automatic pulse(input int which);
        @(posedge core_clk);
        if (which == 0) haltReq <= 1'b1; else if (which == 1) stopReq <= 1'b1;
        else wakeIrq <= 1'b1;
        @(posedge core_clk);
        haltReq <= 1'b0; stopReq <= 1'b0; wakeIrq <= 1'b0;
        repeat (3) @(negedge core_clk);
    endtask

    // Counts enable pulses of one output over a window of cycles
    task automatic cnt(input int idx, input int cyc, output int c);
        c = 0;
        repeat (cyc)
        begin
            @(negedge core_clk);
            if (enVec[idx] === 1'b1) c++;
        end
    endtask

    // Reset with a configuration word, then time the start-up to CPU run
    task automatic boot(input logic [7:0] opt, output int t);
        @(posedge core_clk);
        srst <= 1'b1; optionWord <= opt;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        chk("enablesInReset", 0, {enVec, cpuRun, secondPinFree});
        @(posedge core_clk);
        srst <= 1'b0;
        t = 0;
        while (cpuRun !== 1'b1 && t < 4000)
        begin
            @(negedge core_clk);
            t++;
        end
    endtask

    // Watchdog
    initial
    begin
        #(40 * 80000);
        miscompares++;
        results();
    end

    initial
    begin
        // Ring source, slow oscillator stoppable
        boot(8'h04, tr);
        chk("ringBootLong", 1, tr >= 1120 && tr < 1200);
        rd(3'h0, rv); chk("cpuDivRst", 8'h02, rv);
        rd(3'h1, rv); chk("perDivRst", 8'h02, rv);
        rd(3'h6, rv); chk("unmapped", 8'h00, rv);
        rd(3'h5, rv); chk("statusRing", 8'h62, rv);
        chk("pinKept", 0, secondPinFree);
        for (int p = 0; p < 3; p++)
        begin
            wr(3'h1, p[7:0]); wr(3'h0, 8'h00); repeat (30) @(posedge core_clk);
            cnt(4, 120, n); chk("perRate", 40 >> p, n);
        end
        wr(3'h1, 8'h00);
        for (int c = 0; c < 3; c++)
        begin
            wr(3'h0, c[7:0]); repeat (30) @(posedge core_clk);
            cnt(5, 120, n); chk("cpuRate", 40 >> c, n);
        end
        wr(3'h1, 8'h03); repeat (30) @(posedge core_clk);
        cnt(4, 120, n); chk("perForbidden", 40, n);
        wr(3'h4, 8'h00); repeat (30) @(posedge core_clk);
        cnt(1, 120, n); chk("wdtOnPer", 40, n);
        wr(3'h4, 8'h02); repeat (2) @(posedge core_clk);
        cnt(1, 1040, n); chk("wdtStopped", 0, n);
        wr(3'h4, 8'h01); repeat (2) @(posedge core_clk);
        cnt(1, 1040, n); chk("wdtOnSlow", 10, n);
        pulse(0); chk("haltCpuRun", 0, cpuRun);
        rd(3'h5, rv); chk("statusHalt", 8'h63, rv);
        cnt(5, 120, n); chk("haltCpuClk", 0, n);
        cnt(4, 120, n); chk("haltPerClk", 40, n);
        cnt(1, 1040, n); chk("haltWdt", 0, n);
        cnt(0, 1040, n); chk("haltAux", 10, n);
        pulse(2); chk("wakeHalt", 1, cpuRun);
        wr(3'h3, 8'h01); repeat (5) @(posedge core_clk);
        cnt(2, 1040, n); chk("slowStopped", 0, n);
        cnt(0, 1040, n); chk("auxStopped", 0, n);
        wr(3'h3, 8'h00); repeat (2) @(posedge core_clk);
        cnt(2, 1040, n); chk("slowRuns", 10, n);
        $display("ring source test done");

        // External source, slow oscillator locked on
        boot(8'h02, te);
        chk("extNoWait", 1, te + 4 >= tr && te <= tr + 4);
        chk("pinFree", 1, secondPinFree);
        rd(3'h5, rv); chk("statusExt", 8'h32, rv);
        cnt(3, 200, n); chk("sysRateExt", 40, n);
        wr(3'h3, 8'h01); cnt(2, 1040, n); chk("slowLocked", 10, n);
        pulse(0); cnt(1, 1040, n); chk("wdtInHalt", 10, n);
        pulse(2);
        pulse(1); chk("stopCpuRun", 0, cpuRun);
        cnt(3, 200, n); chk("stopSysClk", 0, n);
        pulse(2); chk("extWakeFast", 1, cpuRun);
        $display("external source test done");

        // Crystal source, settle code 0 from the configuration word
        boot(8'h01, tc);
        chk("xtalSettle", 1, tc >= te + 16 && tc <= te + 20);
        chk("pinXtal", 0, secondPinFree);
        wr(3'h2, 8'h03); rd(3'h2, rv); chk("wakeReg", 8'h03, rv);
        pulse(1); pulse(2);
        cnt(3, 100, n); chk("xtalWakeSys", 20, n);
        chk("xtalWakeWait", 0, cpuRun);
        n = 100;
        while (cpuRun !== 1'b1 && n < 400)
        begin
            @(negedge core_clk);
            n++;
        end
        chk("xtalWakeLen", 1, n >= 154 && n <= 158);
        $display("crystal source test done");
        results();
    end
endmodule

/* verilog/cspcg_core.sv */
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ns
module cspcg_core #(
    parameter int SETTLE_EXP0 = 10,
    parameter int SETTLE_EXP1 = 12,
    parameter int SETTLE_EXP2 = 15,
    parameter int SETTLE_EXP3 = 17
) (
    input  wire logic       core_clk,
    input  wire logic       srst,
    input  wire logic [7:0] optionWord,
    input  wire logic       firstOscPin,
    input  wire logic       haltReq,
    input  wire logic       stopReq,
    input  wire logic       wakeIrq,
    input  wire logic [2:0] regAddr,
    input  wire logic [7:0] regWdata,
    input  wire logic       regWr,
    input  wire logic       regRd,
    output logic      [7:0] regRdata,
    output logic            cpuClkEn,
    output logic            periphClkEn,
    output logic            sysClkEn,
    output logic            slowClkEn,
    output logic            wdtClkEn,
    output logic            auxTimerClkEn,
    output logic            secondPinFree,
    output logic            cpuRun
);

    cspcg_pkg::cspcg_state_t q;
    cspcg_pkg::cspcg_state_t d;

    logic        slowRun;
    logic        fastTick;
    logic        slowTickRaw;
    logic        slowTick;
    logic        pinEdge;
    logic        sysTick;
    logic        perTick;
    logic        cpuTick;
    logic        wdtTick;
    logic        standby;
    logic        bootDone;
    logic        settleDone;
    logic [1:0]  perMask;
    logic [2:0]  cpuMask;
    logic [17:0] settleLim;

    // Tick sources, dividers and the start-up sequence
    always_comb
    begin
        d = q;
        // Stop bit only counts when the configuration allows it
        slowRun     = !(q.optStopOk && q.regSlowStop);
        fastTick    = (q.fastCnt == 2'(cspcg_pkg::FAST_DIV_CYC - 1));
        slowTickRaw = (q.slowCnt == 7'(cspcg_pkg::SLOW_DIV_CYC - 1));
        slowTick    = slowRun && slowTickRaw;
        pinEdge     = q.pinSync2 && !q.pinPrev;
        standby     = (q.state == cspcg_pkg::ST_HALT) || (q.state == cspcg_pkg::ST_STOP);

        // System clock source follows the latched configuration
        sysTick = (q.optSrc == cspcg_pkg::SRC_RING) ? fastTick : pinEdge;
        if ((q.state == cspcg_pkg::ST_BOOT) || (q.state == cspcg_pkg::ST_STOP))
        begin
            sysTick = 1'b0;
        end

        // Peripheral divide by 1, 2 or 4
        case (q.perAct)
            2'h0:    perMask = 2'h0;
            2'h1:    perMask = 2'h1;
            default: perMask = 2'h3;
        endcase
        perTick = sysTick && (q.perCnt == perMask);

        // CPU divide of the peripheral clock by 1, 2, 4 or 8
        case (q.cpuAct)
            2'h0:    cpuMask = 3'h0;
            2'h1:    cpuMask = 3'h1;
            2'h2:    cpuMask = 3'h3;
            default: cpuMask = 3'h7;
        endcase
        cpuTick = perTick && (q.cpuCnt == cpuMask) && (q.state == cspcg_pkg::ST_RUN);

        // Settle length, in system clock periods
        case (q.settleSel)
            2'h0:    settleLim = 18'(1) << SETTLE_EXP0;
            2'h1:    settleLim = 18'(1) << SETTLE_EXP1;
            2'h2:    settleLim = 18'(1) << SETTLE_EXP2;
            default: settleLim = 18'(1) << SETTLE_EXP3;
        endcase
        settleDone = sysTick && (q.settleCnt == settleLim - 18'(1));

        // First slow tick after the fast phase only opens the count, so the
        // partial slow period never shortens the eight full ones
        bootDone = (q.bootFast == cspcg_pkg::BOOT_FAST_PER) && slowTickRaw
                   && (q.bootSlow == cspcg_pkg::BOOT_SLOW_PER);

        // Watchdog clock routing
        if (!q.optStopOk)
        begin
            wdtTick = slowTickRaw;
        end
        else if (standby)
        begin
            wdtTick = 1'b0;
        end
        else
        begin
            case (q.regWdtSel)
                cspcg_pkg::WDT_SEL_PER:  wdtTick = perTick;
                cspcg_pkg::WDT_SEL_SLOW: wdtTick = slowTick;
                default:                 wdtTick = 1'b0;
            endcase
        end

        // Oscillator models (fast one free-running, slow one held while stopped) and pin synchroniser
        d.fastCnt  = fastTick ? 2'h0 : q.fastCnt + 2'h1;
        if (slowRun)
        begin
            d.slowCnt = slowTickRaw ? 7'h00 : q.slowCnt + 7'h01;
        end
        d.pinSync1 = firstOscPin;
        d.pinSync2 = q.pinSync1;
        d.pinPrev  = q.pinSync2;

        // Dividers reload their ratio only at wrap
        if (sysTick)
        begin
            if (q.perCnt == perMask)
            begin
                d.perCnt = 2'h0;
                if (q.regPerSel != cspcg_pkg::PER_DIV_BAD)
                begin
                    d.perAct = q.regPerSel;
                end
            end
            else
            begin
                d.perCnt = q.perCnt + 2'h1;
            end
        end
        if (perTick)
        begin
            if (q.cpuCnt == cpuMask)
            begin
                d.cpuCnt = 3'h0;
                d.cpuAct = q.regCpuSel;
            end
            else
            begin
                d.cpuCnt = q.cpuCnt + 3'h1;
            end
        end

        // Start-up, settle and standby sequencing
        case (q.state)
            cspcg_pkg::ST_BOOT:
            begin
                if (q.bootFast != cspcg_pkg::BOOT_FAST_PER)
                begin
                    d.bootFast = q.bootFast + 7'(fastTick);
                end
                else if (slowTickRaw)
                begin
                    d.bootSlow = q.bootSlow + 4'h1;
                end
                if (bootDone)
                begin
                    // Configuration word taken here, once
                    d.optSrc    = cspcg_pkg::cspcg_src_t'(
                                  optionWord[cspcg_pkg::OPT_SRC_LSB +: 2]);
                    d.optStopOk = optionWord[cspcg_pkg::OPT_STOPOK_BIT];
                    d.settleSel = optionWord[cspcg_pkg::OPT_SETTLE_LSB +: 2];
                    d.settleCnt = 18'h0_0000;
                    if (optionWord[cspcg_pkg::OPT_SRC_LSB +: 2] == cspcg_pkg::SRC_CRYSTAL)
                    begin
                        d.state = cspcg_pkg::ST_SETTLE;
                    end
                    else
                    begin
                        d.state = cspcg_pkg::ST_RUN;
                    end
                end
            end
            cspcg_pkg::ST_SETTLE:
            begin
                if (settleDone)
                begin
                    d.state = cspcg_pkg::ST_RUN;
                end
                else if (sysTick)
                begin
                    d.settleCnt = q.settleCnt + 18'h0_0001;
                end
            end
            cspcg_pkg::ST_RUN:
            begin
                if (stopReq)
                begin
                    d.state = cspcg_pkg::ST_STOP;
                end
                else if (haltReq)
                begin
                    d.state = cspcg_pkg::ST_HALT;
                end
            end
            cspcg_pkg::ST_HALT:
            begin
                if (wakeIrq)
                begin
                    d.state = cspcg_pkg::ST_RUN;
                end
            end
            cspcg_pkg::ST_STOP:
            begin
                if (wakeIrq)
                begin
                    if (q.optSrc == cspcg_pkg::SRC_CRYSTAL)
                    begin
                        d.state     = cspcg_pkg::ST_SETTLE;
                        d.settleSel = q.regWake;
                        d.settleCnt = 18'h0_0000;
                    end
                    else
                    begin
                        d.state = cspcg_pkg::ST_RUN;
                    end
                end
            end
            default:
            begin
                d.state = cspcg_pkg::ST_BOOT;
            end
        endcase

        // Register writes
        if (regWr)
        begin
            case (regAddr)
                cspcg_pkg::OFS_CPU_DIV:   d.regCpuSel   = regWdata[1:0];
                cspcg_pkg::OFS_PER_DIV:   d.regPerSel   = regWdata[1:0];
                cspcg_pkg::OFS_WAKE:      d.regWake     = regWdata[1:0];
                cspcg_pkg::OFS_SLOW_MODE: d.regSlowStop = regWdata[0];
                cspcg_pkg::OFS_WDT_SEL:   d.regWdtSel   = regWdata[1:0];
                default:                  d.rdata       = q.rdata;
            endcase
        end

        // Register reads, data valid in the following cycle
        d.rdata = 8'h00;
        if (regRd)
        begin
            case (regAddr)
                cspcg_pkg::OFS_CPU_DIV:   d.rdata[1:0] = q.regCpuSel;
                cspcg_pkg::OFS_PER_DIV:   d.rdata[1:0] = q.regPerSel;
                cspcg_pkg::OFS_WAKE:      d.rdata[1:0] = q.regWake;
                cspcg_pkg::OFS_SLOW_MODE: d.rdata[0]   = q.regSlowStop;
                cspcg_pkg::OFS_WDT_SEL:   d.rdata[1:0] = q.regWdtSel;
                cspcg_pkg::OFS_STATUS:
                begin
                    d.rdata[cspcg_pkg::STAT_STATE_LSB +: 3] = q.state;
                    d.rdata[cspcg_pkg::STAT_SRC_LSB +: 2]   = q.optSrc;
                    d.rdata[cspcg_pkg::STAT_SLOW_BIT]       = slowRun;
                    d.rdata[cspcg_pkg::STAT_STOPOK_BIT]     = q.optStopOk;
                end
                default:                  d.rdata = 8'h00;
            endcase
        end

        // Registered clock enables
        d.cpuEn  = cpuTick;
        d.perEn  = perTick;
        d.sysEn  = sysTick;
        d.slowEn = slowTick;
        d.wdtEn  = wdtTick;
        d.auxEn  = slowTick;
    end

    // State register with synchronous reset
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            q           <= '0;
            q.regCpuSel <= cspcg_pkg::RST_CPU_DIV;
            q.regPerSel <= cspcg_pkg::RST_PER_DIV;
            q.cpuAct    <= cspcg_pkg::RST_CPU_DIV;
            q.perAct    <= cspcg_pkg::RST_PER_DIV;
            q.regWake   <= cspcg_pkg::RST_WAKE;
            q.regWdtSel <= cspcg_pkg::RST_WDT_SEL;
        end
        else
        begin
            q <= d;
        end
    end

    // Outputs
    assign regRdata      = q.rdata;
    assign cpuClkEn      = q.cpuEn;
    assign periphClkEn   = q.perEn;
    assign sysClkEn      = q.sysEn;
    assign slowClkEn     = q.slowEn;
    assign wdtClkEn      = q.wdtEn;
    assign auxTimerClkEn = q.auxEn;
    assign secondPinFree = (q.optSrc == cspcg_pkg::SRC_EXT);
    assign cpuRun        = (q.state == cspcg_pkg::ST_RUN);

    // Checks on sequencing and clock routing
    chk_boot_no_cpu: assert property (@(posedge core_clk) disable iff (srst)
        (q.state == cspcg_pkg::ST_BOOT) |=> !cpuClkEn)
        else $error("cpu clock during start-up");
    chk_boot_length: assert property (@(posedge core_clk) disable iff (srst)
        ($past(q.state) == cspcg_pkg::ST_BOOT && q.state != cspcg_pkg::ST_BOOT)
        |-> ($past(q.bootSlow) == cspcg_pkg::BOOT_SLOW_PER
             && $past(q.bootFast) == cspcg_pkg::BOOT_FAST_PER))
        else $error("start-up halt ended early");
    chk_settle_hold: assert property (@(posedge core_clk) disable iff (srst)
        (q.state == cspcg_pkg::ST_SETTLE) ##1 (q.state == cspcg_pkg::ST_SETTLE)
        |-> !cpuClkEn)
        else $error("cpu clock during settle");
    chk_wake_sel: assert property (@(posedge core_clk) disable iff (srst)
        ($past(q.state) == cspcg_pkg::ST_STOP && q.state == cspcg_pkg::ST_SETTLE)
        |-> (q.settleSel == $past(q.regWake)))
        else $error("wake settle not from register");
    chk_settle_len: assert property (@(posedge core_clk) disable iff (srst)
        ($past(q.state) == cspcg_pkg::ST_SETTLE && q.state == cspcg_pkg::ST_RUN)
        |-> ($past(q.settleCnt) == $past(settleLim) - 18'h0_0001))
        else $error("settle length wrong");
    chk_no_wait: assert property (@(posedge core_clk) disable iff (srst)
        (q.state == cspcg_pkg::ST_STOP && q.optSrc != cspcg_pkg::SRC_CRYSTAL && wakeIrq)
        |=> (q.state == cspcg_pkg::ST_RUN))
        else $error("wait inserted on wake");
    chk_div_reset: assert property (@(posedge core_clk)
        srst |=> (q.regCpuSel == 2'h2 && q.perAct == 2'h2))
        else $error("divider selects not 02H after reset");
    chk_halt_entry: assert property (@(posedge core_clk) disable iff (srst)
        (q.state == cspcg_pkg::ST_RUN && haltReq && !stopReq)
        |=> (q.state == cspcg_pkg::ST_HALT) ##1 !cpuClkEn)
        else $error("halt not entered");
    chk_div_boundary: assert property (@(posedge core_clk) disable iff (srst)
        $changed(q.perAct) |-> $past(perTick))
        else $error("peripheral ratio changed mid period");
    chk_wdt_locked: assert property (@(posedge core_clk) disable iff (srst)
        (!q.optStopOk && slowTickRaw) |=> wdtClkEn)
        else $error("locked watchdog clock missing");
    chk_wdt_standby: assert property (@(posedge core_clk) disable iff (srst)
        (q.optStopOk && standby) |=> !wdtClkEn)
        else $error("watchdog clocked in standby");

endmodule

/* verilog/cspcg_pkg.sv */
package cspcg_pkg;

    // Core clock and nominal oscillator rates, in Hz
    localparam int CORE_CLK_HZ  = 32'h017D_7840;
    localparam int SLOW_OSC_HZ  = 32'h0003_A980;
    localparam int FAST_OSC_HZ  = 32'h007A_1200;

    // Core cycles per oscillator period (tick enables)
    localparam int SLOW_DIV_CYC = CORE_CLK_HZ / SLOW_OSC_HZ;
    localparam int FAST_DIV_CYC = CORE_CLK_HZ / FAST_OSC_HZ;

    // Start-up halt: fast periods first, then slow periods
    localparam logic [6:0] BOOT_FAST_PER = 7'h60;
    localparam logic [3:0] BOOT_SLOW_PER = 4'h8;

    // Register offsets
    localparam logic [2:0] OFS_CPU_DIV    = 3'h0;
    localparam logic [2:0] OFS_PER_DIV    = 3'h1;
    localparam logic [2:0] OFS_WAKE       = 3'h2;
    localparam logic [2:0] OFS_SLOW_MODE  = 3'h3;
    localparam logic [2:0] OFS_WDT_SEL    = 3'h4;
    localparam logic [2:0] OFS_STATUS     = 3'h5;

    // Reset values
    localparam logic [1:0] RST_CPU_DIV  = 2'h2;
    localparam logic [1:0] RST_PER_DIV  = 2'h2;
    localparam logic [1:0] RST_WAKE     = 2'h0;
    localparam logic [1:0] RST_WDT_SEL  = 2'h1;

    // Divider select codes
    localparam logic [1:0] PER_DIV_BAD  = 2'h3;

    // Watchdog clock select codes
    localparam logic [1:0] WDT_SEL_PER  = 2'h0;
    localparam logic [1:0] WDT_SEL_SLOW = 2'h1;

    // Configuration word fields
    localparam int OPT_SRC_LSB    = 0;
    localparam int OPT_STOPOK_BIT = 2;
    localparam int OPT_SETTLE_LSB = 3;

    // Status register field positions
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_SRC_LSB   = 3;
    localparam int STAT_SLOW_BIT  = 5;
    localparam int STAT_STOPOK_BIT = 6;

    typedef enum logic [1:0] {
        SRC_RING    = 2'b00,
        SRC_CRYSTAL = 2'b01,
        SRC_EXT     = 2'b10
    } cspcg_src_t;

    typedef enum logic [2:0] {
        ST_BOOT   = 3'b000,
        ST_SETTLE = 3'b001,
        ST_RUN    = 3'b010,
        ST_HALT   = 3'b011,
        ST_STOP   = 3'b100
    } cspcg_fsm_t;

    typedef struct packed {
        cspcg_fsm_t  state;
        cspcg_src_t  optSrc;
        logic        optStopOk;
        logic [1:0]  settleSel;
        logic [17:0] settleCnt;
        logic [6:0]  bootFast;
        logic [3:0]  bootSlow;
        logic [1:0]  fastCnt;
        logic [6:0]  slowCnt;
        logic        pinSync1;
        logic        pinSync2;
        logic        pinPrev;
        logic [1:0]  perCnt;
        logic [1:0]  perAct;
        logic [2:0]  cpuCnt;
        logic [1:0]  cpuAct;
        logic [1:0]  regCpuSel;
        logic [1:0]  regPerSel;
        logic [1:0]  regWake;
        logic        regSlowStop;
        logic [1:0]  regWdtSel;
        logic [7:0]  rdata;
        logic        cpuEn;
        logic        perEn;
        logic        sysEn;
        logic        slowEn;
        logic        wdtEn;
        logic        auxEn;
    } cspcg_state_t;

endpackage
